// ==== shared/pcimrd_defines.vh ====
// constants for the pci master read path: state width, status and cause codes, widths, fifo sizing
// assumes a single 125 MHz pci clock shared by bus and back end
`ifndef PCIMRD_DEFINES_VH
`define PCIMRD_DEFINES_VH

`define PCIMRD_AD_W         32
`define PCIMRD_BE_W         4
`define PCIMRD_LEN_W        8
`define PCIMRD_STAT_W       4
`define PCIMRD_TERM_W       2
`define PCIMRD_ST_W         3
`define PCIMRD_FIFO_DEPTH   16
`define PCIMRD_FIFO_AW      4

`define PCIMRD_STAT_IDLE    4'h0
`define PCIMRD_STAT_LOAD    4'h1
`define PCIMRD_STAT_TXN     4'h2
`define PCIMRD_STAT_TERM    4'h3

`define PCIMRD_TERM_NONE    2'h0
`define PCIMRD_TERM_NORMAL  2'h1

`define PCIMRD_LEN_ZERO     8'h00
`define PCIMRD_LEN_ONE      8'h01
`define PCIMRD_AD_ZERO      32'h00000000
`define PCIMRD_BE_ONES      4'hF
`define PCIMRD_ROOM_MIN     5'h02

`endif

// ==== verilog/pcimrd_master_read.v ====
// pci master read path: address phase, data phases with initiator wait states, turnaround, idle
// assumes synchronous inputs on clk_i, an external pad stage resolving the oe_n pairs to the bus
`include "pcimrd_defines.vh"

// read-word buffer between the pci data phases and the local master
module pcimrd_fifo #(parameter WIDTH = 32, parameter DEPTH = 16, parameter AW = 4) (
  input  wire             clk_i,
  input  wire             sys_rst_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire [AW:0]      level_o
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_q, rd_ptr_q;
  reg  [AW:0]      count_q;
  wire             push, pop;

  function [AW-1:0] ptr_next;
    input [AW-1:0] p;
    begin
      ptr_next = (p == DEPTH - 1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  assign in_ready_o  = (count_q != DEPTH);
  assign out_valid_o = (count_q != {(AW+1){1'b0}});
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rd_ptr_q];
  assign level_o     = count_q;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_entry
      always @(posedge clk_i)
        if (push && (wr_ptr_q == i))
          mem[i] <= in_data_i;
    end
  endgenerate

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_q <= ptr_next(wr_ptr_q);
      if (pop)
        rd_ptr_q <= ptr_next(rd_ptr_q);
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end
endmodule // pcimrd_fifo

// Overview of operation
// [RULE_01] one cycle after address loading with the grant held, frame is asserted with address, command and bus-transaction status.
// [RULE_02] the local master drops its request after seeing address loading unless it wants another transaction queued.
// [RULE_03] in the address phase the remaining-burst count is loaded with the latched burst length.
// [RULE_04] the local master gives first byte enables with ready in the address phase and holds ready off until it can take data.
// [RULE_05] reqn is withdrawn the cycle after frame was asserted while the local request was already off.
// [RULE_06] in the read turnaround ad floats, first byte enables drive, irdyn follows last cycle's ready and frame holds if more phases remain.
// [RULE_07] the local grant output follows the pci grant input; the code holds it deasserted while idle.
// [RULE_08] each completed data phase gives its word locally a cycle later, decrements the count, and strobes only if ready was on the cycle before.
// [RULE_09] irdyn is deasserted as a wait state when local ready was off the cycle before and reasserted when it returns;
// code: an asserted irdyn holds until its data phase completes.
// [RULE_10] on the final data phase irdyn is asserted and framen deasserted together.
// [RULE_11] during an initiator wait state the target holds devseln, trdyn and the read word steady.
// [RULE_12] in the turnaround after the last phase irdyn is deasserted and frame, ad and cbe are released.
// [RULE_13] when trdyn and irdyn were both asserted the cycle before, status becomes bus termination with normal termination cause; code: last phase only.
// [RULE_14] in the idle cycle after the turnaround irdyn is released.
// [RULE_15] when the local request and the grant were both asserted the cycle before, status becomes address loading and address, command and length latch;
// code: only from the grant state, which is entered the cycle after the grant is first seen while requesting.
// [RULE_16] the 4-bit local status uses fixed distinct codes for idle, address loading, bus transaction and bus termination.
module pcimrd_master_read (
  input  wire                        clk_i,
  input  wire                        sys_rst_i,
  input  wire                        local_req_32bit_n_i,
  input  wire [`PCIMRD_AD_W-1:0]     local_addr_i,
  input  wire [`PCIMRD_BE_W-1:0]     local_cmd_i,
  input  wire [`PCIMRD_LEN_W-1:0]    local_burst_length_in_i,
  input  wire                        local_ready_n_i,
  input  wire [`PCIMRD_BE_W-1:0]     local_byte_enable_in_i,
  output wire                        local_grant_n_o,
  output wire                        local_word_strobe_n_o,
  output wire [`PCIMRD_AD_W-1:0]     local_read_data_o,
  output wire [`PCIMRD_LEN_W-1:0]    remaining_burst_count_o,
  output wire [`PCIMRD_STAT_W-1:0]   local_xfer_status_o,
  output wire [`PCIMRD_TERM_W-1:0]   termination_cause_o,
  input  wire                        gnt_n_i,
  output wire                        req_n_o,
  input  wire                        trdy_n_i,
  input  wire                        devsel_n_i,
  input  wire [`PCIMRD_AD_W-1:0]     ad_i,
  output wire [`PCIMRD_AD_W-1:0]     ad_o,
  output wire                        ad_oe_n_o,
  output wire [`PCIMRD_BE_W-1:0]     cbe_n_o,
  output wire                        cbe_oe_n_o,
  output wire                        frame_n_o,
  output wire                        frame_oe_n_o,
  output wire                        irdy_n_o,
  output wire                        irdy_oe_n_o
);
  localparam [`PCIMRD_ST_W-1:0] S_IDLE  = 3'h0;
  localparam [`PCIMRD_ST_W-1:0] S_REQ   = 3'h1;
  localparam [`PCIMRD_ST_W-1:0] S_GRANT = 3'h2;
  localparam [`PCIMRD_ST_W-1:0] S_LOAD  = 3'h3;
  localparam [`PCIMRD_ST_W-1:0] S_ADDR  = 3'h4;
  localparam [`PCIMRD_ST_W-1:0] S_DATA  = 3'h5;
  localparam [`PCIMRD_ST_W-1:0] S_TURN  = 3'h6;
  localparam [`PCIMRD_ST_W-1:0] S_REL   = 3'h7;

  reg  [`PCIMRD_ST_W-1:0]   state_q, state_d;
  reg  [`PCIMRD_AD_W-1:0]   addr_q;
  reg  [`PCIMRD_BE_W-1:0]   cmd_q;
  reg  [`PCIMRD_LEN_W-1:0]  len_q;
  reg  [`PCIMRD_LEN_W-1:0]  cnt_q, cnt_d;
  reg  [`PCIMRD_STAT_W-1:0] status_q, status_d;
  reg  [`PCIMRD_TERM_W-1:0] term_q, term_d;
  reg                       req_n_q, req_n_d;
  reg                       lgnt_n_q;
  reg                       rdy_q;
  reg  [`PCIMRD_AD_W-1:0]   ad_q;
  reg                       ad_oe_n_q, ad_oe_n_d;
  reg  [`PCIMRD_BE_W-1:0]   cbe_q, cbe_d;
  reg                       cbe_oe_n_q, cbe_oe_n_d;
  reg                       frame_n_q, frame_n_d;
  reg                       frame_oe_n_q, frame_oe_n_d;
  reg                       irdy_n_q, irdy_n_d;
  reg                       irdy_oe_n_q, irdy_oe_n_d;
  reg  [`PCIMRD_LEN_W-1:0]  left;
  wire                      complete;
  wire                      fifo_in_ready, fifo_out_valid;
  wire [`PCIMRD_FIFO_AW:0]  fifo_level;
  wire                      room, want_irdy;

  // a data phase finishes when both ready signals were low at this edge
  assign complete  = (state_q == S_DATA) & ~irdy_n_q & ~trdy_n_i;
  // keep space for the word that may land while irdy is committed
  assign room      = fifo_in_ready & (fifo_level <= (`PCIMRD_FIFO_DEPTH - `PCIMRD_ROOM_MIN));
  assign want_irdy = ~local_ready_n_i & room;                                   // [RULE_09]

  pcimrd_fifo #(.WIDTH (`PCIMRD_AD_W), .DEPTH (`PCIMRD_FIFO_DEPTH), .AW (`PCIMRD_FIFO_AW)) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (complete),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (ad_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (rdy_q),
    .out_data_o  (local_read_data_o),
    .level_o     (fifo_level)
  );

  // word is offered the cycle after its phase; strobe only when ready was on last cycle
  assign local_word_strobe_n_o   = ~(fifo_out_valid & rdy_q);                   // [RULE_08]
  assign local_grant_n_o         = lgnt_n_q;
  assign remaining_burst_count_o = cnt_q;
  assign local_xfer_status_o     = status_q;
  assign termination_cause_o     = term_q;
  assign req_n_o                 = req_n_q;
  assign ad_o                    = ad_q;
  assign ad_oe_n_o               = ad_oe_n_q;
  assign cbe_n_o                 = cbe_q;
  assign cbe_oe_n_o              = cbe_oe_n_q;
  assign frame_n_o               = frame_n_q;
  assign frame_oe_n_o            = frame_oe_n_q;
  assign irdy_n_o                = irdy_n_q;
  assign irdy_oe_n_o             = irdy_oe_n_q;

  always @*
  begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    status_d     = status_q;
    term_d       = term_q;
    req_n_d      = req_n_q;
    ad_oe_n_d    = ad_oe_n_q;
    cbe_d        = cbe_q;
    cbe_oe_n_d   = cbe_oe_n_q;
    frame_n_d    = frame_n_q;
    frame_oe_n_d = frame_oe_n_q;
    irdy_n_d     = irdy_n_q;
    irdy_oe_n_d  = irdy_oe_n_q;
    left         = cnt_q - {{(`PCIMRD_LEN_W-1){1'b0}}, complete};
    case (state_q)
      S_IDLE:
      begin
        status_d = `PCIMRD_STAT_IDLE;                                           // [RULE_16]
        req_n_d  = local_req_32bit_n_i;
        state_d  = local_req_32bit_n_i ? S_IDLE : S_REQ;
      end
      S_REQ:
        if (!gnt_n_i)
          state_d = S_GRANT;
      S_GRANT:
      begin
        if (!gnt_n_i && !local_req_32bit_n_i)
        begin
          status_d = `PCIMRD_STAT_LOAD;                                         // [RULE_15]
          term_d   = `PCIMRD_TERM_NONE;
          state_d  = S_LOAD;
        end
        else if (gnt_n_i)
          state_d = S_REQ;
      end
      S_LOAD:
      begin
        state_d = S_REQ;
        if (!gnt_n_i)
        begin
          frame_n_d    = 1'b0;                                                  // [RULE_01]
          frame_oe_n_d = 1'b0;
          ad_oe_n_d    = 1'b0;
          cbe_d        = cmd_q;
          cbe_oe_n_d   = 1'b0;
          status_d     = `PCIMRD_STAT_TXN;
          cnt_d        = len_q;                                                 // [RULE_03]
          irdy_n_d     = 1'b1;
          irdy_oe_n_d  = 1'b0;
          state_d      = (len_q == `PCIMRD_LEN_ZERO) ? S_TURN : S_ADDR;
        end
      end
      S_ADDR:
      begin
        req_n_d   = req_n_q | local_req_32bit_n_i;                              // [RULE_05]
        ad_oe_n_d = 1'b1;                                                       // [RULE_06]
        cbe_d     = local_byte_enable_in_i;
        irdy_n_d  = ~want_irdy;
        frame_n_d = want_irdy & (cnt_q == `PCIMRD_LEN_ONE);                     // [RULE_10]
        state_d   = S_DATA;
      end
      S_DATA:
      begin
        req_n_d = req_n_q | (~frame_n_q & local_req_32bit_n_i);                 // [RULE_05]
        cnt_d   = left;                                                         // [RULE_08]
        if (left == `PCIMRD_LEN_ZERO)
        begin
          irdy_n_d     = 1'b1;                                                  // [RULE_12]
          frame_n_d    = 1'b1;
          frame_oe_n_d = 1'b1;
          cbe_oe_n_d   = 1'b1;
          cbe_d        = `PCIMRD_BE_ONES;
          status_d     = `PCIMRD_STAT_TERM;                                     // [RULE_13]
          term_d       = `PCIMRD_TERM_NORMAL;
          state_d      = S_TURN;
        end
        else
        begin
          // an asserted irdy stays committed until its phase completes
          irdy_n_d = ~(want_irdy | (~irdy_n_q & ~complete));                    // [RULE_09]
          if (complete)
            cbe_d = local_byte_enable_in_i;
          if (frame_n_q == 1'b0)
            frame_n_d = ~irdy_n_d & (left == `PCIMRD_LEN_ONE);                  // [RULE_10]
        end
      end
      S_TURN:
      begin
        irdy_n_d     = 1'b1;
        irdy_oe_n_d  = 1'b1;                                                    // [RULE_14]
        frame_n_d    = 1'b1;
        frame_oe_n_d = 1'b1;
        ad_oe_n_d    = 1'b1;
        cbe_oe_n_d   = 1'b1;
        status_d     = `PCIMRD_STAT_TERM;
        term_d       = `PCIMRD_TERM_NORMAL;
        req_n_d      = req_n_q | local_req_32bit_n_i;
        state_d      = S_REL;
      end
      S_REL:
      begin
        status_d = `PCIMRD_STAT_IDLE;
        state_d  = S_IDLE;
      end
      default:
        state_d = S_IDLE;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q      <= S_IDLE;
      addr_q       <= `PCIMRD_AD_ZERO;
      cmd_q        <= `PCIMRD_BE_ONES;
      len_q        <= `PCIMRD_LEN_ZERO;
      cnt_q        <= `PCIMRD_LEN_ZERO;
      status_q     <= `PCIMRD_STAT_IDLE;
      term_q       <= `PCIMRD_TERM_NONE;
      req_n_q      <= 1'b1;
      lgnt_n_q     <= 1'b1;
      rdy_q        <= 1'b0;
      ad_q         <= `PCIMRD_AD_ZERO;
      ad_oe_n_q    <= 1'b1;
      cbe_q        <= `PCIMRD_BE_ONES;
      cbe_oe_n_q   <= 1'b1;
      frame_n_q    <= 1'b1;
      frame_oe_n_q <= 1'b1;
      irdy_n_q     <= 1'b1;
      irdy_oe_n_q  <= 1'b1;
    end
    else
    begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      status_q     <= status_d;
      term_q       <= term_d;
      req_n_q      <= req_n_d;
      rdy_q        <= ~local_ready_n_i;
      ad_oe_n_q    <= ad_oe_n_d;
      cbe_q        <= cbe_d;
      cbe_oe_n_q   <= cbe_oe_n_d;
      frame_n_q    <= frame_n_d;
      frame_oe_n_q <= frame_oe_n_d;
      irdy_n_q     <= irdy_n_d;
      irdy_oe_n_q  <= irdy_oe_n_d;
      lgnt_n_q     <= (state_q == S_IDLE) ? 1'b1 : gnt_n_i;                    // [RULE_07]
      if ((state_q == S_GRANT) && !gnt_n_i && !local_req_32bit_n_i)
      begin
        addr_q <= local_addr_i;                                                 // [RULE_15]
        cmd_q  <= local_cmd_i;
        len_q  <= local_burst_length_in_i;
      end
      // address goes out whenever the address phase drives ad, zero-length bursts included
      ad_q <= ad_oe_n_d ? `PCIMRD_AD_ZERO : addr_q;                             // [RULE_01]
    end
  end
endmodule // pcimrd_master_read

// ==== bench/pcimrd_master_read_monitor.sv ====
// checker for the pci master read path
// assumes a bind to pcimrd_master_read and its single clock
`include "pcimrd_defines.vh"
module pcimrd_master_read_monitor (
  input logic        clk_i,
  input logic        sys_rst_i,
  input logic        local_req_32bit_n_i,
  input logic [31:0] local_addr_i,
  input logic [3:0]  local_cmd_i,
  input logic [7:0]  local_burst_length_in_i,
  input logic        local_ready_n_i,
  input logic [3:0]  local_byte_enable_in_i,
  input logic        local_grant_n_o,
  input logic        local_word_strobe_n_o,
  input logic [7:0]  remaining_burst_count_o,
  input logic [3:0]  local_xfer_status_o,
  input logic [1:0]  termination_cause_o,
  input logic        gnt_n_i,
  input logic        req_n_o,
  input logic        trdy_n_i,
  input logic [31:0] ad_o,
  input logic        ad_oe_n_o,
  input logic [3:0]  cbe_n_o,
  input logic        cbe_oe_n_o,
  input logic        frame_n_o,
  input logic        frame_oe_n_o,
  input logic        irdy_n_o,
  input logic        irdy_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire [3:0] st = local_xfer_status_o;
  wire [7:0] cnt = remaining_burst_count_o;
  wire ld = st == `PCIMRD_STAT_LOAD;
  wire txn = st == `PCIMRD_STAT_TXN;
  wire done = !irdy_n_o && !trdy_n_i && txn;
  sequence s_last; done && frame_n_o; endsequence
  sequence s_tail; irdy_oe_n_o && st == `PCIMRD_STAT_TERM ##1 st == `PCIMRD_STAT_IDLE; endsequence
  load_entry_a: assert property ($rose(ld) |-> $past(!local_req_32bit_n_i && !gnt_n_i))
    else $error("address loading without request and grant");
  frame_start_a: assert property (ld && !gnt_n_i |=> !frame_n_o && !frame_oe_n_o && txn && !ad_oe_n_o
    && !cbe_oe_n_o && ad_o == $past(local_addr_i, 2) && cbe_n_o == $past(local_cmd_i, 2))
    else $error("address phase wrong");
  count_load_a: assert property (ld && !gnt_n_i |=> cnt == $past(local_burst_length_in_i, 2))
    else $error("burst count not loaded");
  req_drop_a: assert property (!frame_n_o && !frame_oe_n_o && local_req_32bit_n_i |=> req_n_o)
    else $error("request not withdrawn");
  turn_around_a: assert property ($rose(txn) |=> ad_oe_n_o && !cbe_oe_n_o
    && cbe_n_o == $past(local_byte_enable_in_i) && irdy_n_o == $past(local_ready_n_i))
    else $error("read turnaround wrong");
  grant_follow_a: assert property (!req_n_o || gnt_n_i |=> local_grant_n_o == $past(gnt_n_i))
    else $error("local grant does not track grant");
  wait_insert_a: assert property (txn && ad_oe_n_o && local_ready_n_i && (irdy_n_o || !trdy_n_i) |=> irdy_n_o)
    else $error("no wait state");
  wait_resume_a: assert property (txn && ad_oe_n_o && irdy_n_o && !local_ready_n_i |=> !irdy_n_o)
    else $error("ready not resumed");
  last_phase_a: assert property (txn && !irdy_n_o |-> frame_n_o == (cnt == 8'h01))
    else $error("frame wrong against remaining count");
  count_dec_a: assert property (done |=> cnt == $past(cnt) - 8'h01)
    else $error("count not decremented");
  strobe_cause_a: assert property (!local_word_strobe_n_o |-> $past(!local_ready_n_i))
    else $error("strobe without ready");
  bus_end_a: assert property (s_last |=> irdy_n_o && !irdy_oe_n_o && frame_oe_n_o && ad_oe_n_o && cbe_oe_n_o
    && st == `PCIMRD_STAT_TERM && termination_cause_o == `PCIMRD_TERM_NORMAL ##1 s_tail)
    else $error("termination sequence wrong");
endmodule // pcimrd_master_read_monitor

bind pcimrd_master_read pcimrd_master_read_monitor u_pcimrd_master_read_monitor (.*);

// ==== bench/pcimrd_target_model.sv ====
// behavioural pci target answering burst reads with counting words
// assumes resolved frame and irdy levels, pulled up when released
module pcimrd_target_model (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        stall_i,
  input  wire logic        frame_n_i,
  input  wire logic        irdy_n_i,
  output logic             trdy_n_o,
  output logic             devsel_n_o,
  output wire logic [31:0] ad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        act_q;
  logic [31:0] w_q;
  // released bus shows the inverse so stale data never matches
  assign ad_o = (act_q && !devsel_n_o) ? w_q : ~w_q;
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      act_q <= 1'h0;
      trdy_n_o <= 1'h1;
      devsel_n_o <= 1'h1;
      w_q <= 32'h5A5A0000;
    end
    else if (!irdy_n_i && !trdy_n_o)
    begin
      w_q <= w_q + 32'h1;
      trdy_n_o <= frame_n_i | stall_i;
      act_q <= !frame_n_i;
      devsel_n_o <= frame_n_i;
    end
    else if (!act_q && !frame_n_i)
    begin
      act_q <= 1'h1;
      devsel_n_o <= 1'h0;
    end
    else if (act_q && !stall_i)
      trdy_n_o <= 1'h0; // an asserted trdy, devsel and word hold through wait states
  end
endmodule // pcimrd_target_model

// ==== bench/tb_pcimrd_master_read.sv ====
// self-checking bench for the pci master read path
// assumes the target model on the bus side and pull-ups on frame and irdy
`include "pcimrd_defines.vh"
module tb_pcimrd_master_read;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'h0;
  logic        sys_rst_i = 1'h1;
  logic        local_req_32bit_n_i = 1'h1;
  logic [31:0] local_addr_i = 32'h0;
  logic [3:0]  local_cmd_i = 4'h6;
  logic [7:0]  local_burst_length_in_i = 8'h0;
  logic        local_ready_n_i = 1'h1;
  logic [3:0]  local_byte_enable_in_i = 4'hA;
  logic        gnt_n_i = 1'h1;
  logic        stall = 1'h0;
  logic [31:0] exp_w = 32'h5A5A0000;
  int          fails = 0;
  int          compares = 0;
  wire         local_grant_n_o, local_word_strobe_n_o, req_n_o, trdy_n_i, devsel_n_i;
  wire         ad_oe_n_o, cbe_oe_n_o, frame_n_o, frame_oe_n_o, irdy_n_o, irdy_oe_n_o;
  wire [31:0]  local_read_data_o, ad_o, ad_i, tgt_ad;
  wire [7:0]   remaining_burst_count_o;
  wire [3:0]   local_xfer_status_o, cbe_n_o;
  wire [1:0]   termination_cause_o;
  assign ad_i = ad_oe_n_o ? tgt_ad : ad_o;
  always #4 clk_i = ~clk_i;
  pcimrd_master_read u_pcimrd_master_read (.*);
  pcimrd_target_model u_pcimrd_target_model (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .stall_i   (stall),
    .frame_n_i (frame_oe_n_o | frame_n_o),
    .irdy_n_i  (irdy_oe_n_o | irdy_n_o),
    .trdy_n_o  (trdy_n_i),
    .devsel_n_o(devsel_n_i),
    .ad_o      (tgt_ad)
  );
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] len, input logic [31:0] pat, input logic sten);
    int c;
    logic [7:0] got;
    got = 8'h0;
    @(negedge clk_i);
    local_req_32bit_n_i = 1'h0;
    local_addr_i = {24'hC01000, len};
    local_burst_length_in_i = len;
    @(negedge clk_i);
    chk("request", req_n_o, 1'h0);
    @(negedge clk_i);
    gnt_n_i = 1'h0;
    for (c = 0; c < 20 && local_xfer_status_o !== `PCIMRD_STAT_LOAD; c++)
      @(negedge clk_i);
    if (c == 20)
    begin
      chk("grant wait", 1'h0, 1'h1);
      complete_run;
    end
    @(negedge clk_i);
    chk("status", local_xfer_status_o, `PCIMRD_STAT_TXN);
    local_req_32bit_n_i = 1'h1;
    local_ready_n_i = pat[0];
    for (c = 1; c < 400 && (local_xfer_status_o !== `PCIMRD_STAT_IDLE || got < len); c++)
    begin
      @(negedge clk_i);
      if (local_word_strobe_n_o === 1'h0)
      begin
        chk("word", local_read_data_o, exp_w);
        exp_w++;
        got++;
      end
      if (local_xfer_status_o === `PCIMRD_STAT_TERM)
      begin
        chk("cause", termination_cause_o, `PCIMRD_TERM_NORMAL);
        gnt_n_i <= 1'h1;
      end
      local_ready_n_i <= pat[c % 32] && local_xfer_status_o === `PCIMRD_STAT_TXN;
      stall <= sten & c[1];
    end
    if (c == 400)
    begin
      chk("completion", 1'h0, 1'h1);
      complete_run;
    end
    chk("words", got, len);
    chk("count", remaining_burst_count_o, 8'h0);
    chk("irdy oe", irdy_oe_n_o, 1'h1);
  endtask
  task automatic t_reset;
    chk("status", local_xfer_status_o, `PCIMRD_STAT_IDLE);
    chk("cause", termination_cause_o, `PCIMRD_TERM_NONE);
    chk("bus idle", {req_n_o, local_grant_n_o, frame_oe_n_o, irdy_oe_n_o, ad_oe_n_o}, 5'h1F);
    $display("test reset done");
  endtask
  task automatic t_wait;
    xfer(8'h03, 32'h00000008, 1'h0);
    $display("test local wait done");
  endtask
  task automatic t_single;
    xfer(8'h01, 32'h0, 1'h0);
    $display("test single phase done");
  endtask
  task automatic t_long;
    xfer(8'h14, 32'h24924924, 1'h1);
    $display("test long stalled burst done");
  endtask
  task automatic t_back;
    xfer(8'h02, 32'h0, 1'h0);
    xfer(8'h02, 32'h00000002, 1'h1);
    $display("test back to back done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'h0;
    t_reset;
    t_wait;
    t_single;
    t_long;
    t_back;
    complete_run;
  end
endmodule // tb_pcimrd_master_read
